//--- hw/boundary_scan_test_port.v
// Boundary-scan test access port, oversampled on the system clock
// Function
// (RQ1) Sample/preload captures pins without disturbing core; preload shifts pattern for update.
// (RQ2) External test drives pins from update stage and captures input pins.
// (RQ3) Bypass puts one-bit register between serial in and out, one clock delay.
// (RQ4) User-signature instruction selects user signature register for serial shift out.
// (RQ5) Identification instruction selects 32-bit identification register for shifting out.
// (RQ6) Instruction register is ten bits; controller shifts exactly ten bits.
// (RQ7) User signature is 32 bits: seven configured bits, twenty-five fixed bits.
// (RQ8) Boundary register length is a build parameter; controller shifts matching count.
// (RQ9) Identification: version 4, part 16, maker 11 bits, lsb one.
// (RQ10) Boundary tests accepted only before or after configuration, never during.
// (RQ11) Configuration load instruction streams configuration bytes from the serial port.
// (RQ12) User outputs stay high impedance until operating conditions are reached.
// (RQ13) Sixteen-state controller on rising clock; serial out on falling, shift states only.
// (RQ14) All-ones and undefined codes are bypass; reset loads identification instruction.
`timescale 1ns/1ps
`include "boundary_scan_regs.vh"
module boundary_scan_test_port #(
  parameter        BSR_LEN    = `BSR_LEN_DEF,
  parameter        NUM_PINS   = BSR_LEN / `CELLS_PER_PIN,
  parameter        FIFO_DEPTH = `CFG_FIFO_DEPTH,
  parameter        FIFO_AW    = 5,
  parameter [3:0]  ID_VERSION = 4'h6, // Arbitrary
  parameter [15:0] ID_PART    = 16'h0abc, // Arbitrary
  parameter [10:0] ID_MAKER   = 11'h155, // Arbitrary
  parameter [24:0] USR_FIXED  = 25'h0123456
) (
  input  wire                   i_sys_clk,
  input  wire                   i_rst,
  input  wire                   i_tck,
  input  wire                   i_tms,
  input  wire                   i_tdi,
  output wire                   o_tdo,
  output wire                   o_tdo_oe,
  input  wire [`USR_SEL_W-1:0]  i_user_sig,
  input  wire                   i_config_active,
  input  wire                   i_user_mode,
  input  wire [NUM_PINS-1:0]    i_pin_in,
  output wire [NUM_PINS-1:0]    o_pin_out,
  output wire [NUM_PINS-1:0]    o_pin_oe,
  input  wire [NUM_PINS-1:0]    i_core_out,
  input  wire [NUM_PINS-1:0]    i_core_oe,
  output wire [NUM_PINS-1:0]    o_core_in,
  output wire                   o_cfg_valid,
  input  wire                   i_cfg_ready,
  output wire [`CFG_BYTE_W-1:0] o_cfg_data,
  output wire                   o_cfg_overflow
);
  localparam [15:0] S_TLR  = 16'h0001;
  localparam [15:0] S_RTI  = 16'h0002;
  localparam [15:0] S_SDR  = 16'h0004;
  localparam [15:0] S_CDR  = 16'h0008;
  localparam [15:0] S_SHDR = 16'h0010;
  localparam [15:0] S_E1DR = 16'h0020;
  localparam [15:0] S_PDR  = 16'h0040;
  localparam [15:0] S_E2DR = 16'h0080;
  localparam [15:0] S_UDR  = 16'h0100;
  localparam [15:0] S_SIR  = 16'h0200;
  localparam [15:0] S_CIR  = 16'h0400;
  localparam [15:0] S_SHIR = 16'h0800;
  localparam [15:0] S_E1IR = 16'h1000;
  localparam [15:0] S_PIR  = 16'h2000;
  localparam [15:0] S_E2IR = 16'h4000;
  localparam [15:0] S_UIR  = 16'h8000;

  reg  [2:0]             tck_s_r;
  reg  [1:0]             tms_s_r;
  reg  [1:0]             tdi_s_r;
  reg  [NUM_PINS-1:0]    pin_s1_r;
  reg  [NUM_PINS-1:0]    pin_s2_r;
  reg  [15:0]            tap_r;
  reg  [15:0]            tap_nxt;
  reg  [`IR_LEN-1:0]     ir_sh_r;
  reg  [`IR_LEN-1:0]     ir_r;
  reg                    bypass_r;
  reg  [`ID_LEN-1:0]     id_sh_r;
  reg  [BSR_LEN-1:0]     bsr_sh_r;
  reg  [BSR_LEN-1:0]     bsr_upd_r;
  reg  [`CFG_BYTE_W-1:0] cfg_sh_r;
  reg  [2:0]             cfg_cnt_r;
  reg  [`CFG_BYTE_W-1:0] cfg_byte_r;
  reg                    cfg_pend_r;
  reg                    cfg_ovf_r;
  reg                    tdo_r;
  reg                    tdo_oe_r;
  reg                    dr_out;
  wire                   tck_rise;
  wire                   tck_fall;
  wire                   tms;
  wire                   tdi;
  wire                   fifo_ready;
  wire [BSR_LEN-1:0]     bsr_cap;
  wire                   scan_test_ok;
  wire                   sel_ext;
  wire                   sel_smp;
  wire                   sel_id;
  wire                   sel_usr;
  wire                   sel_cfg;
  wire                   sel_byp;
  wire [`ID_LEN-1:0]     id_word;
  wire [`USR_LEN-1:0]    usr_word;

  assign tck_rise = tck_s_r[1] & ~tck_s_r[2];
  assign tck_fall = ~tck_s_r[1] & tck_s_r[2];
  assign tms      = tms_s_r[1];
  assign tdi      = tdi_s_r[1];

  // Identification and signature words
  assign id_word  = {ID_VERSION, ID_PART, ID_MAKER, 1'b1}; // [RQ9] [RQ5]
  assign usr_word = {USR_FIXED, i_user_sig}; // [RQ7]

  // Instruction decode
  assign scan_test_ok = ~i_config_active; // [RQ10]
  assign sel_ext = (ir_r == `OP_EXTEST) & scan_test_ok; // [RQ2] [RQ10]
  assign sel_smp = (ir_r == `OP_SAMPLE) & scan_test_ok; // [RQ1] [RQ10]
  assign sel_id  = (ir_r == `OP_DEV_IDENT); // [RQ5]
  assign sel_usr = (ir_r == `OP_USER_SIG); // [RQ4]
  assign sel_cfg = (ir_r == `OP_CFG_LOAD); // [RQ11]
  assign sel_byp = ~(sel_ext | sel_smp | sel_id | sel_usr | sel_cfg); // [RQ14] [RQ3]

  // Input synchronisers
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tck_s_r  <= 3'h7;
      tms_s_r  <= 2'h3;
      tdi_s_r  <= 2'h0;
      pin_s1_r <= {NUM_PINS{1'b0}};
      pin_s2_r <= {NUM_PINS{1'b0}};
    end
    else
    begin
      tck_s_r  <= {tck_s_r[1:0], i_tck};
      tms_s_r  <= {tms_s_r[0], i_tms};
      tdi_s_r  <= {tdi_s_r[0], i_tdi};
      pin_s1_r <= i_pin_in;
      pin_s2_r <= pin_s1_r;
    end
  end

  // Controller next state
  always @*
  begin
    case (tap_r) // [RQ13]
      S_TLR:   tap_nxt = tms ? S_TLR  : S_RTI;
      S_RTI:   tap_nxt = tms ? S_SDR  : S_RTI;
      S_SDR:   tap_nxt = tms ? S_SIR  : S_CDR;
      S_CDR:   tap_nxt = tms ? S_E1DR : S_SHDR;
      S_SHDR:  tap_nxt = tms ? S_E1DR : S_SHDR;
      S_E1DR:  tap_nxt = tms ? S_UDR  : S_PDR;
      S_PDR:   tap_nxt = tms ? S_E2DR : S_PDR;
      S_E2DR:  tap_nxt = tms ? S_UDR  : S_SHDR;
      S_UDR:   tap_nxt = tms ? S_SDR  : S_RTI;
      S_SIR:   tap_nxt = tms ? S_TLR  : S_CIR;
      S_CIR:   tap_nxt = tms ? S_E1IR : S_SHIR;
      S_SHIR:  tap_nxt = tms ? S_E1IR : S_SHIR;
      S_E1IR:  tap_nxt = tms ? S_UIR  : S_PIR;
      S_PIR:   tap_nxt = tms ? S_E2IR : S_PIR;
      S_E2IR:  tap_nxt = tms ? S_UIR  : S_SHIR;
      S_UIR:   tap_nxt = tms ? S_SDR  : S_RTI;
      default: tap_nxt = S_TLR;
    endcase
  end

  // Serial output source
  always @*
  begin
    if (tap_r == S_SHIR)
      dr_out = ir_sh_r[0];
    else if (sel_ext | sel_smp)
      dr_out = bsr_sh_r[0];
    else if (sel_id | sel_usr)
      dr_out = id_sh_r[0];
    else if (sel_cfg)
      dr_out = cfg_sh_r[0];
    else
      dr_out = bypass_r; // [RQ3]
  end

  // Capture values per pin: input, output and enable cells
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g = g + 1)
    begin : g_cell
      assign bsr_cap[3*g]   = pin_s2_r[g]; // [RQ1] [RQ2]
      assign bsr_cap[3*g+1] = i_core_out[g];
      assign bsr_cap[3*g+2] = i_core_oe[g];
      assign o_pin_out[g]   = sel_ext ? bsr_upd_r[3*g+1] : i_core_out[g]; // [RQ2]
      assign o_pin_oe[g]    = i_user_mode & (sel_ext ? bsr_upd_r[3*g+2] : i_core_oe[g]); // [RQ12]
      assign o_core_in[g]   = sel_ext ? bsr_upd_r[3*g] : pin_s2_r[g];
    end
  endgenerate

  // Controller and shift paths on sampled clock rise
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tap_r     <= S_TLR;
      ir_sh_r   <= {`IR_LEN{1'b0}};
      ir_r      <= `OP_DEV_IDENT;
      bypass_r  <= 1'b0;
      id_sh_r   <= {`ID_LEN{1'b0}};
      bsr_sh_r  <= {BSR_LEN{1'b0}};
      bsr_upd_r <= {BSR_LEN{1'b0}};
      cfg_sh_r  <= {`CFG_BYTE_W{1'b0}};
      cfg_cnt_r <= 3'h0;
    end
    else if (tck_rise)
    begin
      tap_r <= tap_nxt; // [RQ13]
      case (tap_r)
        S_TLR:
          ir_r <= `OP_DEV_IDENT; // [RQ14]
        S_CIR:
          ir_sh_r <= `IR_CAPTURE;
        S_SHIR:
          ir_sh_r <= {tdi, ir_sh_r[`IR_LEN-1:1]}; // [RQ6]
        S_UIR:
          ir_r <= ir_sh_r; // [RQ6]
        S_CDR:
        begin
          bypass_r  <= 1'b0;
          cfg_cnt_r <= 3'h0;
          if (sel_ext | sel_smp)
            bsr_sh_r <= bsr_cap; // [RQ1] [RQ2]
          if (sel_id)
            id_sh_r <= id_word; // [RQ5]
          else if (sel_usr)
            id_sh_r <= usr_word; // [RQ4]
        end
        S_SHDR:
        begin
          bypass_r <= tdi & sel_byp; // [RQ3] [RQ14]
          if (sel_ext | sel_smp)
            bsr_sh_r <= {tdi, bsr_sh_r[BSR_LEN-1:1]}; // [RQ8]
          if (sel_id | sel_usr)
            id_sh_r <= {tdi, id_sh_r[`ID_LEN-1:1]}; // [RQ4] [RQ5]
          if (sel_cfg)
          begin
            cfg_sh_r  <= {tdi, cfg_sh_r[`CFG_BYTE_W-1:1]}; // [RQ11]
            cfg_cnt_r <= cfg_cnt_r + 3'h1;
          end
        end
        S_UDR:
          if (sel_ext | sel_smp)
            bsr_upd_r <= bsr_sh_r; // [RQ1] [RQ2]
        default:
          bypass_r <= bypass_r;
      endcase
    end
  end

  // Configuration byte hand-off into the FIFO
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cfg_byte_r <= {`CFG_BYTE_W{1'b0}};
      cfg_pend_r <= 1'b0;
      cfg_ovf_r  <= 1'b0;
    end
    else
    begin
      if (tck_rise && tap_r == S_SHDR && sel_cfg && cfg_cnt_r == 3'h7)
      begin
        if (cfg_pend_r && !fifo_ready)
          cfg_ovf_r <= 1'b1; // [RQ11]
        else
        begin
          cfg_byte_r <= {tdi, cfg_sh_r[`CFG_BYTE_W-1:1]};
          cfg_pend_r <= 1'b1;
        end
      end
      else if (cfg_pend_r && fifo_ready)
        cfg_pend_r <= 1'b0;
      if (tck_rise && tap_r == S_TLR)
        cfg_ovf_r <= 1'b0;
    end
  end

  // Serial output on falling clock, enabled in shift states only
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tdo_r    <= 1'b0;
      tdo_oe_r <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_r    <= dr_out; // [RQ13]
      tdo_oe_r <= (tap_r == S_SHDR) | (tap_r == S_SHIR); // [RQ13]
    end
  end

  assign o_tdo          = tdo_r;
  assign o_tdo_oe       = tdo_oe_r;
  assign o_cfg_overflow = cfg_ovf_r;

  stream_fifo #(
    .WIDTH (`CFG_BYTE_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_cfg_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_rst       (i_rst),
    .i_in_valid  (cfg_pend_r),
    .o_in_ready  (fifo_ready),
    .i_in_data   (cfg_byte_r),
    .o_out_valid (o_cfg_valid),
    .i_out_ready (i_cfg_ready),
    .o_out_data  (o_cfg_data)
  );
endmodule

//--- hw/stream_fifo.v
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module stream_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             i_sys_clk,
  input  wire             i_rst,
  input  wire             i_in_valid,
  output wire             o_in_ready,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_out_valid,
  input  wire             i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg  [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg  [AW:0]      wr_ptr_r;
  reg  [AW:0]      rd_ptr_r;
  wire             full;
  wire             empty;
  wire             push;
  wire             pop;

  assign full        = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign empty       = (wr_ptr_r == rd_ptr_r);
  assign o_in_ready  = ~full;
  assign o_out_valid = ~empty;
  assign o_out_data  = mem_r[rd_ptr_r[AW-1:0]];
  assign push        = i_in_valid & ~full;
  assign pop         = i_out_ready & ~empty;

  always @(posedge i_sys_clk)
  begin
    if (push)
      mem_r[wr_ptr_r[AW-1:0]] <= i_in_data;
  end

  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wr_ptr_r <= {(AW+1){1'b0}};
      rd_ptr_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
endmodule

//--- shared/boundary_scan_regs.vh
// Instruction codes, register widths and capture value for the scan port
`ifndef BOUNDARY_SCAN_REGS_VH
`define BOUNDARY_SCAN_REGS_VH
`define IR_LEN          10
`define IR_CAPTURE      10'h001
`define OP_EXTEST       10'h000
`define OP_CFG_LOAD     10'h002
`define OP_SAMPLE       10'h005
`define OP_DEV_IDENT    10'h006
`define OP_USER_SIG     10'h007
`define OP_BYPASS       10'h3ff
`define ID_LEN          32
`define ID_VER_LSB      28
`define ID_PART_LSB     12
`define ID_MFR_LSB      1
`define USR_LEN         32
`define USR_SEL_W       7
`define BSR_LEN_DEF     690
`define CELLS_PER_PIN   3
`define CFG_BYTE_W      8
`define CFG_FIFO_DEPTH  32
`endif

//--- sim/boundary_scan_test_port_checker.sv
// Concurrent checks on the scan port's outputs
`timescale 1ns/1ps
module boundary_scan_test_port_checker #(
  parameter NUM_PINS = 230
) (
  input wire                i_sys_clk,
  input wire                i_rst,
  input wire                i_tck,
  input wire                i_tms,
  input wire                i_user_mode,
  input wire                i_cfg_ready,
  input wire                o_tdo,
  input wire                o_tdo_oe,
  input wire [NUM_PINS-1:0] o_pin_oe,
  input wire                o_cfg_valid,
  input wire [7:0]          o_cfg_data,
  input wire                o_cfg_overflow
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  a_pin_oe_gated: assert property (!i_user_mode |-> o_pin_oe == '0)
    else $error("pin enable outside user mode");
  a_tdo_on_low: assert property ($changed(o_tdo) |-> !i_tck)
    else $error("serial out moved while test clock high");
  a_tdo_oe_low: assert property ($changed(o_tdo_oe) |-> !i_tck)
    else $error("serial enable moved while test clock high");
  a_reset_idle: assert property ($fell(i_rst) |-> !o_tdo_oe && !o_cfg_valid && !o_cfg_overflow)
    else $error("outputs busy after reset");
  a_valid_hold: assert property (o_cfg_valid && !i_cfg_ready |=> o_cfg_valid)
    else $error("byte withdrawn while stalled");
  a_data_hold: assert property (o_cfg_valid && !i_cfg_ready |=> $stable(o_cfg_data))
    else $error("byte changed while stalled");
  a_ovf_full: assert property ($rose(o_cfg_overflow) |-> o_cfg_valid)
    else $error("overflow with empty buffer");
  a_ovf_sticky: assert property (o_cfg_overflow && !i_tck |=> o_cfg_overflow)
    else $error("overflow cleared while test clock low");
  c_shift: cover property ($rose(o_tdo_oe));
  c_pop: cover property (o_cfg_valid && i_cfg_ready);
  c_ovf: cover property ($rose(o_cfg_overflow));
endmodule
bind boundary_scan_test_port boundary_scan_test_port_checker #(.NUM_PINS(NUM_PINS)) u_chk (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_tck(i_tck), .i_tms(i_tms),
  .i_user_mode(i_user_mode), .i_cfg_ready(i_cfg_ready), .o_tdo(o_tdo),
  .o_tdo_oe(o_tdo_oe), .o_pin_oe(o_pin_oe), .o_cfg_valid(o_cfg_valid),
  .o_cfg_data(o_cfg_data), .o_cfg_overflow(o_cfg_overflow)
);

//--- sim/boundary_scan_test_port_test.sv
// Self-checking bench for the scan port
`timescale 1ns/1ps
`include "boundary_scan_regs.vh"
module boundary_scan_test_port_test;
  localparam BSR = 690;
  localparam NP = BSR / 3;
  localparam [3:0] IDV = 4'h9; // Arbitrary
  localparam [15:0] IDP = 16'h5c3e; // Arbitrary
  localparam [10:0] IDM = 11'h2a7; // Arbitrary
  localparam [24:0] USRF = 25'h0a5a5a5; // Arbitrary
  logic          sys_clk, rst, tck, tms, tdi, tdo, tdo_oe;
  logic          cfg_active, user_mode, cfg_ready, cfg_valid, cfg_ovf;
  logic [6:0]    user_sig;
  logic [7:0]    cfg_data;
  logic [NP-1:0] pin_in, pin_out, pin_oe, core_out, core_oe, core_in;
  logic [1023:0] q, e, d;
  int            errors, checked, i;
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  jtag_host u_host (.i_sys_clk(sys_clk), .i_tdo(tdo), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
  boundary_scan_test_port #(.BSR_LEN(BSR), .ID_VERSION(IDV), .ID_PART(IDP), .ID_MAKER(IDM),
    .USR_FIXED(USRF)) u_dut (
    .i_sys_clk(sys_clk), .i_rst(rst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo),
    .o_tdo_oe(tdo_oe), .i_user_sig(user_sig), .i_config_active(cfg_active),
    .i_user_mode(user_mode), .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
    .i_core_out(core_out), .i_core_oe(core_oe), .o_core_in(core_in), .o_cfg_valid(cfg_valid),
    .i_cfg_ready(cfg_ready), .o_cfg_data(cfg_data), .o_cfg_overflow(cfg_ovf));
  task chk(input logic [1023:0] got, input logic [1023:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #300000;
    errors++;
    summarize;
  end
  initial
  begin
    errors = 0;
    checked = 0;
    rst = 1'b1;
    cfg_active = 1'b0;
    user_mode = 1'b1;
    cfg_ready = 1'b0;
    user_sig = 7'h5a;
    core_out = '1;
    for (i = 0; i < NP; i++)
    begin
      pin_in[i] = ~i[0];
      core_oe[i] = i[0];
    end
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    u_host.reset_tap;
    u_host.scan(1'b0, 32, '0, q);
    chk(q, {IDV, IDP, IDM, 1'b1});
    chk(tdo_oe, 1'b0);
    $display("ident done");
    u_host.scan(1'b1, 10, `OP_USER_SIG, q);
    chk(q, `IR_CAPTURE);
    u_host.scan(1'b0, 32, '0, q);
    chk(q, {USRF, user_sig});
    $display("user signature done");
    for (i = 0; i < 2; i++)
    begin
      u_host.scan(1'b1, 10, i ? 10'h155 : `OP_BYPASS, q);
      u_host.scan(1'b0, 8, 8'hc9, q);
      chk(q, 8'h92);
    end
    $display("bypass done");
    e = '0;
    d = '0;
    for (i = 0; i < NP; i++)
    begin
      e[3*i] = pin_in[i];
      e[3*i+1] = core_out[i];
      e[3*i+2] = core_oe[i];
      d[3*i+1] = i[0];
      d[3*i+2] = 1'b1;
    end
    u_host.scan(1'b1, 10, `OP_SAMPLE, q);
    u_host.scan(1'b0, BSR, d, q);
    chk(q, e);
    chk(pin_out, core_out);
    chk(pin_oe, core_oe);
    chk(core_in, pin_in);
    $display("sample done");
    u_host.scan(1'b1, 10, `OP_EXTEST, q);
    e = '0;
    for (i = 0; i < NP; i++)
      e[i] = i[0];
    chk(pin_out, e);
    chk(pin_oe, {NP{1'b1}});
    user_mode <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(pin_oe, '0);
    user_mode <= 1'b1;
    cfg_active <= 1'b1;
    u_host.scan(1'b1, 10, `OP_EXTEST, q);
    chk(pin_out, core_out);
    cfg_active <= 1'b0;
    $display("external test done");
    u_host.scan(1'b1, 10, `OP_CFG_LOAD, q);
    for (i = 0; i < 34; i++)
      d[8*i +: 8] = 8'(i + 'h40);
    u_host.scan(1'b0, 272, d, q);
    repeat (4) @(posedge sys_clk);
    chk(cfg_ovf, 1'b1);
    cfg_ready <= 1'b1;
    for (i = 0; i < 33; i++)
    begin
      @(negedge sys_clk);
      chk({cfg_valid, cfg_data}, {1'b1, 8'(i + 'h40)});
    end
    @(negedge sys_clk);
    chk(cfg_valid, 1'b0);
    @(posedge sys_clk);
    cfg_ready <= 1'b0;
    u_host.reset_tap;
    chk(cfg_ovf, 1'b0);
    $display("config load done");
    summarize;
  end
endmodule

//--- sim/jtag_host.sv
// Test controller model driving the serial port
`timescale 1ns/1ps
module jtag_host (
  input  wire  i_sys_clk,
  input  wire  i_tdo,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi
);
  localparam HALF = 20;
  initial
  begin
    o_tck = 1'b1;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  // One test clock period, serial out taken just before the rise
  task step(input logic m, input logic di, output logic o);
    @(posedge i_sys_clk);
    o_tck <= 1'b0;
    o_tms <= m;
    o_tdi <= di;
    repeat (HALF) @(posedge i_sys_clk);
    o = i_tdo;
    o_tck <= 1'b1;
    repeat (HALF) @(posedge i_sys_clk);
  endtask
  // Five rises with mode high, then idle
  task reset_tap;
    logic o;
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
  // Full scan from idle back to idle, first bit first
  task scan(input logic ir, input int n, input logic [1023:0] d, output logic [1023:0] q);
    logic o;
    int   i;
    q = '0;
    step(1'b1, 1'b0, o);
    if (ir)
      step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (i = 0; i < n; i++)
    begin
      step(i == n - 1, d[i], o);
      q[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
endmodule
